// File: pkg/hdbp_defines.svh
`ifndef HDBP_DEFINES_SVH
`define HDBP_DEFINES_SVH

// clock figures in ns; the core period equals the aclk period
`define HDBP_ACLK_PERIOD_NS   25
`define HDBP_CORE_PERIOD_NS  25
`define HDBP_REQ_DROP_NS     (3 * `HDBP_CORE_PERIOD_NS)
`define HDBP_REARM_NS        (16 * `HDBP_CORE_PERIOD_NS)
// longest times round down, least times round up
`define HDBP_REQ_DROP_CYC    (`HDBP_REQ_DROP_NS / `HDBP_ACLK_PERIOD_NS)
`define HDBP_REARM_CYC       ((`HDBP_REARM_NS + `HDBP_ACLK_PERIOD_NS - 1) / `HDBP_ACLK_PERIOD_NS)

// register byte offsets
`define HDBP_REG_CTRL        12'h000
`define HDBP_REG_FRAME_SIZE  12'h004
`define HDBP_REG_READY       12'h008
`define HDBP_REG_IRQ_STATUS  12'h00c
`define HDBP_REG_IRQ_MASK    12'h010
`define HDBP_REG_ADDR        12'h014
`define HDBP_BUF_BASE        12'h100

// control bits
`define HDBP_CTRL_TX_DMA_EN  0
`define HDBP_CTRL_RX_DMA_EN  1
`define HDBP_CTRL_TX_IE      2
`define HDBP_CTRL_RX_IE      3
`define HDBP_CTRL_TX_SINGLE  4
`define HDBP_CTRL_RX_SINGLE  5
`define HDBP_CTRL_W          6
`define HDBP_CTRL_RESET      6'h00

// ready and interrupt status bits
`define HDBP_BIT_TX          0
`define HDBP_BIT_RX          1

// host address bits [3:1] that select the data ports
`define HDBP_DATA_PORT_SEL   3'h1

`define HDBP_RESP_OKAY       2'h0
`define HDBP_RESP_SLVERR     2'h2

`endif

// File: pkg/hdbp_pkg.sv
package hdbp_pkg;

	typedef enum logic [1:0] {
		hdbp_dma_idle = 2'b00,
		hdbp_dma_req  = 2'b01,
		hdbp_dma_hold = 2'b10
	} hdbp_dma_state_type;

endpackage : hdbp_pkg

// File: test/hdbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host cpu or dma controller on the byte port
module hdbp_host_model (
	input  wire logic       aclk,
	input  wire logic [7:0] host_data_bus_out,
	input  wire logic       host_data_bus_oe,
	output logic            host_chip_select_n,
	output logic            host_write_strobe_n,
	output logic            host_read_strobe_n,
	output logic            tx_dma_ack_n,
	output logic            rx_dma_ack_n,
	output logic [3:0]      host_addr_bus,
	output logic [7:0]      host_data_bus_in
);
	initial {host_chip_select_n, host_write_strobe_n, host_read_strobe_n, tx_dma_ack_n, rx_dma_ack_n} = 5'h1f;
	initial {host_addr_bus, host_data_bus_in} = 12'h000;
	////////////////////////////////////////////////////////////////
	// ack replaces select
	task xfer(input logic wr, input logic dma, input logic lsb, input logic [7:0] d, output logic [7:0] q);
		{host_chip_select_n, tx_dma_ack_n, rx_dma_ack_n} <= {dma, !(dma & wr), !(dma & !wr)};
		{host_write_strobe_n, host_read_strobe_n, host_addr_bus, host_data_bus_in} <= {!wr, wr, 3'h1, lsb, d};
		// three low edges, clear of the two-cycle minimum
		repeat (3) @(posedge aclk);
		// a byte counts only while the port drives it
		q = host_data_bus_out & {8{host_data_bus_oe}};
		{host_write_strobe_n, host_read_strobe_n} <= 2'h3;
		@(posedge aclk);
		// released line shows the inverse, never the last byte
		{host_chip_select_n, tx_dma_ack_n, rx_dma_ack_n, host_data_bus_in} <= {3'h7, ~d};
		repeat (2) @(posedge aclk);
	endtask : xfer
endmodule : hdbp_host_model
`default_nettype wire

// File: test/hdbp_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hdbp_host_port_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, w, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q, rsp;
	logic [3:0]  s_axi_wstrb = 4'hf, host_addr_bus;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  host_data_bus_in, host_data_bus_out, b;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_rvalid, host_chip_select_n, host_write_strobe_n, host_read_strobe_n;
	logic        tx_dma_ack_n, rx_dma_ack_n, tx_dma_request, rx_dma_request, host_interrupt_n, host_data_bus_oe, irq;
	int          fails = 0, checks_done = 0;
	always #12.5 aclk = ~aclk;
	hdbp_host_port dut_u (.*);
	hdbp_host_model host_u (.*);
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		fails += (g !== e);
		if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
	endtask : chk
	task stop_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// axi writes hold each valid until its own ready
	task wr(input logic [11:0] a, input logic [31:0] d);
		w = 1'b1;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		while (w) begin
			@(posedge aclk);
			{s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & !s_axi_awready, s_axi_wvalid & !s_axi_wready};
			if (s_axi_bvalid) {s_axi_bready, w, rsp} <= {2'h0, 30'h0, s_axi_bresp};
		end
	endtask : wr
	task rd(input logic [11:0] a);
		w = 1'b1;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		while (w) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) {s_axi_rready, w, q, rsp} <= {2'h0, s_axi_rdata, 30'h0, s_axi_rresp};
		end
	endtask : rd
	// a hang counts as a mismatch
	initial begin #100us; fails++; stop_test; end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h0f0);
		chk("rresp", 32'h2, rsp);
		wr(12'h0f0, 32'h1);
		chk("bresp", 32'h2, rsp);
		wr(12'h004, 32'h2);
		chk("bresp", 32'h0, rsp);
		wr(12'h010, 32'h1);
		wr(12'h008, 32'h1);
		@(posedge aclk);
		chk("txreq", 32'h0, tx_dma_request);
		wr(12'h000, 32'h5);
		chk("txreq", 32'h1, tx_dma_request);
		chk("intn", 32'h0, host_interrupt_n);
		for (int i = 0; i < 4; i++) begin
			host_u.xfer(1'b1, i < 2, i[0], 8'h11 * i[7:0], b);
			rd(12'h014);
			chk("txaddr", (i + 1) / 2, q[7:0]);
		end
		chk("txreq", 32'h0, tx_dma_request);
		chk("intn", 32'h1, host_interrupt_n);
		chk("irq", 32'h1, irq);
		rd(12'h008);
		chk("ready", 32'h0, q);
		rd(12'h100);
		chk("txword", 32'h1100, q);
		rd(12'h104);
		chk("txword", 32'h3322, q);
		wr(12'h00c, 32'h1);
		chk("irq", 32'h0, irq);
		$display("transmit test done");
		wr(12'h100, 32'hbbaa);
		wr(12'h104, 32'hddcc);
		wr(12'h000, 32'h2a);
		wr(12'h008, 32'h2);
		@(posedge aclk);
		chk("intn", 32'h0, host_interrupt_n);
		for (int i = 0; i < 4; i++) begin
			chk("rxreq", 32'h1, rx_dma_request);
			host_u.xfer(1'b0, 1'b1, i[0], 8'h00, b);
			chk("rxbyte", 32'haa + 32'h11 * i, b);
			chk("rxreq", 32'h0, rx_dma_request);
			repeat (9) @(posedge aclk);
			chk("rxreq", 32'h0, rx_dma_request);
			repeat (9) @(posedge aclk);
		end
		rd(12'h008);
		chk("ready", 32'h0, q);
		wr(12'h008, 32'h3);
		rd(12'h014);
		chk("addr", 32'h0, q);
		$display("receive test done");
		// transmit in single-cycle style, one-word frame
		wr(12'h004, 32'h1);
		wr(12'h000, 32'h11);
		wr(12'h008, 32'h1);
		chk("txreq", 32'h1, tx_dma_request);
		host_u.xfer(1'b1, 1'b1, 1'b0, 8'h5a, b);
		chk("txreq", 32'h0, tx_dma_request);
		host_u.xfer(1'b1, 1'b1, 1'b1, 8'ha5, b);
		rd(12'h100);
		chk("txword", 32'ha55a, q);
		rd(12'h008);
		chk("ready", 32'h2, q);
		$display("single test done");
		stop_test;
	end
endmodule : hdbp_host_port_tb
`default_nettype wire

// File: verilog/hdbp_dma_req.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdbp_defines.svh"

module hdbp_dma_req (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	input  wire logic frame_ready,
	input  wire logic frame_end,
	input  wire logic single_style,
	input  wire logic dma_ack_n,
	output logic      dma_request
);

	localparam int DROP_MAX = `HDBP_REQ_DROP_CYC;
	localparam int REARM    = `HDBP_REARM_CYC;

	hdbp_pkg::hdbp_dma_state_type state_ff;
	hdbp_pkg::hdbp_dma_state_type nxt_state;
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic       req_ff;
	logic       nxt_req;
	logic       go;
	logic [4:0] gap_ff;

	// frame_end kills the request on the same edge that clears ready
	assign go = enable & frame_ready & ~frame_end;

	////////////////////////////////////////////////////////////
	// request sequencing: burst holds it for the frame, single drops per ack
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_req   = 1'b0;
		unique case (state_ff)
			hdbp_pkg::hdbp_dma_idle: begin
				if (go) begin
					nxt_state = hdbp_pkg::hdbp_dma_req;
					nxt_req   = 1'b1;
				end
			end
			hdbp_pkg::hdbp_dma_req: begin
				// burst or single; single drops on ack
				if (!go)
					nxt_state = hdbp_pkg::hdbp_dma_idle;
				else if (single_style && !dma_ack_n) begin
					nxt_state = hdbp_pkg::hdbp_dma_hold;
					nxt_cnt   = '0;
				end else
					nxt_req = 1'b1;
			end
			hdbp_pkg::hdbp_dma_hold: begin
				if (cnt_ff != 5'(REARM - 1))
					nxt_cnt = cnt_ff + 5'h01;
				else if (dma_ack_n)
					nxt_state = hdbp_pkg::hdbp_dma_idle;
			end
			default: nxt_state = hdbp_pkg::hdbp_dma_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= hdbp_pkg::hdbp_dma_idle;
			cnt_ff   <= 5'h00;
			req_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			req_ff   <= nxt_req;
		end
	end

	assign dma_request = req_ff;

	////////////////////////////////////////////////////////////
	// helper: cycles since request last fell, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gap_ff <= 5'h1f;
		else if (req_ff)
			gap_ff <= 5'h00;
		else if (gap_ff != 5'h1f)
			gap_ff <= gap_ff + 5'h01;
	end

	req_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		req_ff |-> $past(enable)) else $error("request without dma enable");
	ack_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		single_style && req_ff && !dma_ack_n |-> ##[1:DROP_MAX] !req_ff)
		else $error("request not withdrawn after ack");
	rearm_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(req_ff) && single_style && $past(state_ff, 2) == hdbp_pkg::hdbp_dma_hold
		|-> gap_ff >= 5'(REARM)) else $error("request rearmed too soon");
	end_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_end |=> !req_ff) else $error("request held after final strobe");

	burst_c: cover property (@(posedge aclk) disable iff (!aresetn)
		!single_style && req_ff && !dma_ack_n ##1 req_ff);
	single_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(req_ff) && gap_ff == 5'(REARM + 1));

endmodule : hdbp_dma_req
`default_nettype wire

// File: verilog/hdbp_frame_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdbp_defines.svh"

module hdbp_frame_port #(
	parameter int AW = 5
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          strobe_n,
	input  wire logic          selected,
	input  wire logic          addr_lsb,
	input  wire logic [AW:0]   frame_size,
	input  wire logic          set_ready,
	output logic               ready,
	output logic [AW-1:0]      word_addr,
	output logic               access,
	output logic               lane,
	output logic               frame_end
);

	logic          prev_strobe_ff;
	logic          prev_sel_ff;
	logic          prev_lsb_ff;
	logic          ready_ff;
	logic          ready_d_ff;
	logic [AW-1:0] addr_ff;
	logic          step;

	////////////////////////////////////////////////////////////
	// an access completes on the strobe's rising edge; select and lsb are
	// taken from the cycle before, since both may drop right after it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_strobe_ff <= 1'b1;
			prev_sel_ff    <= 1'b0;
			prev_lsb_ff    <= 1'b0;
		end else begin
			prev_strobe_ff <= strobe_n;
			prev_sel_ff    <= selected;
			prev_lsb_ff    <= addr_lsb;
		end
	end

	assign access = prev_sel_ff & ~prev_strobe_ff & strobe_n;
	assign lane   = prev_lsb_ff;
	assign step   = access & prev_lsb_ff & ready_ff;
	assign frame_end = step && ({1'b0, addr_ff} + (AW+1)'(1) == frame_size);

	// ready drops on the edge after the final strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_ff   <= 1'b0;
			ready_d_ff <= 1'b0;
		end else begin
			ready_ff   <= set_ready | (ready_ff & ~frame_end);  // set wins over clear
			ready_d_ff <= ready_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			addr_ff <= '0;
		else if (ready_ff & ~ready_d_ff)
			addr_ff <= '0;
		else if (step)
			addr_ff <= addr_ff + AW'(1);
	end

	assign ready     = ready_ff;
	assign word_addr = addr_ff;

	////////////////////////////////////////////////////////////
	// check address clear
	addr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ready_ff) |=> addr_ff == '0) else $error("address not cleared on ready rise");
	addr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		step && !(ready_ff && !ready_d_ff) |=> addr_ff == $past(addr_ff) + AW'(1))
		else $error("address did not advance");
	ready_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_end && !set_ready |=> !ready_ff) else $error("ready held after final strobe");
	even_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		access && !prev_lsb_ff && !(ready_ff && !ready_d_ff) |=> $stable(addr_ff))
		else $error("address moved on even byte");

	frame_done_c: cover property (@(posedge aclk) disable iff (!aresetn) frame_end);

endmodule : hdbp_frame_port
`default_nettype wire

// File: verilog/hdbp_host_port.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hdbp_defines.svh"

module hdbp_host_port #(
	parameter int DEPTH = 32
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        host_chip_select_n,
	input  wire logic        host_write_strobe_n,
	input  wire logic        host_read_strobe_n,
	input  wire logic [3:0]  host_addr_bus,
	input  wire logic [7:0]  host_data_bus_in,
	output logic [7:0]       host_data_bus_out,
	output logic             host_data_bus_oe,
	input  wire logic        tx_dma_ack_n,
	input  wire logic        rx_dma_ack_n,
	output logic             tx_dma_request,
	output logic             rx_dma_request,
	output logic             host_interrupt_n,
	output logic             irq
);

	localparam int AW = $clog2(DEPTH);

	// byte-enable merge for any 32-bit register write
	function automatic logic [31:0] hdbp_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction : hdbp_merge

	logic [`HDBP_CTRL_W-1:0] ctrl_ff;
	logic [AW:0]             frame_size_ff;
	logic [1:0]              irq_status_ff;
	logic [1:0]              irq_mask_ff;
	logic [1:0]              nxt_irq_status;
	logic [15:0]             tx_mem [DEPTH];
	logic [15:0]             rx_mem [DEPTH];
	logic                    aw_held_ff;
	logic                    w_held_ff;
	logic [11:0]             waddr_ff;
	logic [31:0]             wdata_ff;
	logic [3:0]              wstrb_ff;
	logic                    bvalid_ff;
	logic [1:0]              bresp_ff;
	logic                    arready_ff;
	logic                    rvalid_ff;
	logic [31:0]             rdata_ff;
	logic [1:0]              rresp_ff;
	logic                    do_wr;
	logic                    nxt_aw_held;
	logic                    nxt_w_held;
	logic                    wr_buf;
	logic                    rd_buf;
	logic [AW-1:0]           wr_idx;
	logic [AW-1:0]           rd_idx;
	logic [7:0]              data_in_d_ff;
	logic [7:0]              data_out_ff;
	logic                    data_oe_ff;
	logic                    host_interrupt_n_ff;
	logic                    irq_ff;
	logic                    port_hit;
	logic                    tx_sel;
	logic                    rx_sel;
	logic                    tx_set;
	logic                    rx_set;
	logic                    tx_ready;
	logic                    rx_ready;
	logic [AW-1:0]           tx_addr;
	logic [AW-1:0]           rx_addr;
	logic                    tx_access;
	logic                    rx_access;
	logic                    tx_lane;
	logic                    rx_lane;
	logic                    tx_end;
	logic                    rx_end;

	////////////////////////////////////////////////////////////
	// axi write: address and data taken in either order, answered together
	assign do_wr       = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign nxt_aw_held = do_wr ? 1'b0 : (aw_held_ff | (s_axi_awvalid & s_axi_awready));
	assign nxt_w_held  = do_wr ? 1'b0 : (w_held_ff | (s_axi_wvalid & s_axi_wready));
	assign wr_buf      = waddr_ff >= `HDBP_BUF_BASE && waddr_ff < `HDBP_BUF_BASE + 12'(DEPTH * 4);
	assign wr_idx      = AW'((waddr_ff - `HDBP_BUF_BASE) >> 2);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			waddr_ff      <= 12'h000;
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
		end else begin
			aw_held_ff    <= nxt_aw_held;
			w_held_ff     <= nxt_w_held;
			s_axi_awready <= ~nxt_aw_held;
			s_axi_wready  <= ~nxt_w_held;
			if (s_axi_awvalid && s_axi_awready)
				waddr_ff <= {s_axi_awaddr[11:2], 2'b00};
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `HDBP_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (waddr_ff <= `HDBP_REG_ADDR || wr_buf) ? `HDBP_RESP_OKAY : `HDBP_RESP_SLVERR;
		end else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// control, frame size and mask registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff       <= `HDBP_CTRL_RESET;
			frame_size_ff <= '0;
			irq_mask_ff   <= 2'h0;
		end else if (do_wr) begin
			if (waddr_ff == `HDBP_REG_CTRL)
				ctrl_ff <= `HDBP_CTRL_W'(hdbp_merge(32'(ctrl_ff), wdata_ff, wstrb_ff));
			if (waddr_ff == `HDBP_REG_FRAME_SIZE)
				frame_size_ff <= (AW+1)'(hdbp_merge(32'(frame_size_ff), wdata_ff, wstrb_ff));
			if (waddr_ff == `HDBP_REG_IRQ_MASK)
				irq_mask_ff <= 2'(hdbp_merge(32'(irq_mask_ff), wdata_ff, wstrb_ff));
		end
	end

	// writing a one to a ready bit hands the frame buffer to the host
	assign tx_set = do_wr && waddr_ff == `HDBP_REG_READY && wstrb_ff[0] && wdata_ff[`HDBP_BIT_TX];
	assign rx_set = do_wr && waddr_ff == `HDBP_REG_READY && wstrb_ff[0] && wdata_ff[`HDBP_BIT_RX];

	////////////////////////////////////////////////////////////
	// frame-done events are sticky, write one to clear; a new event wins
	always_comb begin
		nxt_irq_status = irq_status_ff;
		if (do_wr && waddr_ff == `HDBP_REG_IRQ_STATUS && wstrb_ff[0])
			nxt_irq_status = irq_status_ff & ~wdata_ff[1:0];
		nxt_irq_status[`HDBP_BIT_TX] = nxt_irq_status[`HDBP_BIT_TX] | tx_end;
		nxt_irq_status[`HDBP_BIT_RX] = nxt_irq_status[`HDBP_BIT_RX] | rx_end;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_ff <= 2'h0;
			irq_ff        <= 1'b0;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_ff        <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////
	// axi read: one outstanding, answered the cycle after the address
	assign rd_buf = s_axi_araddr >= `HDBP_BUF_BASE && s_axi_araddr < `HDBP_BUF_BASE + 12'(DEPTH * 4);
	assign rd_idx = AW'((s_axi_araddr - `HDBP_BUF_BASE) >> 2);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= `HDBP_RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= `HDBP_RESP_OKAY;
			rdata_ff   <= 32'h00000000;
			if (rd_buf)
				rdata_ff <= 32'(tx_mem[rd_idx]);
			else
				unique case ({s_axi_araddr[11:2], 2'b00})
					`HDBP_REG_CTRL:       rdata_ff <= 32'(ctrl_ff);
					`HDBP_REG_FRAME_SIZE: rdata_ff <= 32'(frame_size_ff);
					`HDBP_REG_READY:      rdata_ff <= 32'({rx_ready, tx_ready});
					`HDBP_REG_IRQ_STATUS: rdata_ff <= 32'(irq_status_ff);
					`HDBP_REG_IRQ_MASK:   rdata_ff <= 32'(irq_mask_ff);
					`HDBP_REG_ADDR:       rdata_ff <= {16'h0000, 8'(rx_addr), 8'(tx_addr)};
					default:              rresp_ff <= `HDBP_RESP_SLVERR;
				endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	// ack stands in for chip select and decode
	assign port_hit = ~host_chip_select_n && host_addr_bus[3:1] == `HDBP_DATA_PORT_SEL;
	assign tx_sel   = port_hit | ~tx_dma_ack_n;
	assign rx_sel   = port_hit | ~rx_dma_ack_n;

	hdbp_frame_port #(.AW(AW)) u_tx_port (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.strobe_n   (host_write_strobe_n),
		.selected   (tx_sel),
		.addr_lsb   (host_addr_bus[0]),
		.frame_size (frame_size_ff),
		.set_ready  (tx_set),
		.ready      (tx_ready),
		.word_addr  (tx_addr),
		.access     (tx_access),
		.lane       (tx_lane),
		.frame_end  (tx_end)
	);

	hdbp_frame_port #(.AW(AW)) u_rx_port (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.strobe_n   (host_read_strobe_n),
		.selected   (rx_sel),
		.addr_lsb   (host_addr_bus[0]),
		.frame_size (frame_size_ff),
		.set_ready  (rx_set),
		.ready      (rx_ready),
		.word_addr  (rx_addr),
		.access     (rx_access),
		.lane       (rx_lane),
		.frame_end  (rx_end)
	);

	hdbp_dma_req u_tx_dma (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.enable       (ctrl_ff[`HDBP_CTRL_TX_DMA_EN]),
		.frame_ready  (tx_ready),
		.frame_end    (tx_end),
		.single_style (ctrl_ff[`HDBP_CTRL_TX_SINGLE]),
		.dma_ack_n    (tx_dma_ack_n),
		.dma_request  (tx_dma_request)
	);

	hdbp_dma_req u_rx_dma (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.enable       (ctrl_ff[`HDBP_CTRL_RX_DMA_EN]),
		.frame_ready  (rx_ready),
		.frame_end    (rx_end),
		.single_style (ctrl_ff[`HDBP_CTRL_RX_SINGLE]),
		.dma_ack_n    (rx_dma_ack_n),
		.dma_request  (rx_dma_request)
	);

	////////////////////////////////////////////////////////////
	// byte storage; the data bus is taken from the cycle before the access, while the strobe is still low
	always_ff @(posedge aclk) begin
		data_in_d_ff <= host_data_bus_in;
		if (tx_access)
			tx_mem[tx_addr][{tx_lane, 3'b000} +: 8] <= data_in_d_ff;
		if (do_wr && wr_buf)
			rx_mem[wr_idx] <= 16'(hdbp_merge(32'(rx_mem[wr_idx]), wdata_ff, wstrb_ff));
	end

	// read data driven while the strobe is low; one cycle access, well inside a strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_out_ff <= 8'h00;
			data_oe_ff  <= 1'b0;
		end else begin
			data_out_ff <= rx_mem[rx_addr][{host_addr_bus[0], 3'b000} +: 8];
			data_oe_ff  <= ~host_read_strobe_n & rx_sel;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			host_interrupt_n_ff <= 1'b1;
		else
			host_interrupt_n_ff <= ~((ctrl_ff[`HDBP_CTRL_TX_IE] & tx_ready & ~tx_end) |
				(ctrl_ff[`HDBP_CTRL_RX_IE] & rx_ready & ~rx_end));
	end

	assign s_axi_bvalid      = bvalid_ff;
	assign s_axi_bresp       = bresp_ff;
	assign s_axi_arready     = arready_ff;
	assign s_axi_rvalid      = rvalid_ff;
	assign s_axi_rdata       = rdata_ff;
	assign s_axi_rresp       = rresp_ff;
	assign host_data_bus_out = data_out_ff;
	assign host_data_bus_oe  = data_oe_ff;
	assign host_interrupt_n  = host_interrupt_n_ff;
	assign irq               = irq_ff;

	////////////////////////////////////////////////////////////
	// check tx end clears ready and request, and the interrupt unless rx is ready
	end_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_end && !tx_set |=> !tx_ready && !tx_dma_request && (host_interrupt_n || rx_ready))
		else $error("tx end not cleared in one cycle");
	tx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_ff[`HDBP_CTRL_TX_IE] && tx_ready && !tx_end |=> !host_interrupt_n)
		else $error("tx ready did not raise interrupt");
	rx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_ff[`HDBP_CTRL_RX_IE] && rx_ready && !rx_end |=> !host_interrupt_n)
		else $error("rx ready did not raise interrupt");
	rx_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_end && !rx_set |=> !rx_ready && !rx_dma_request) else $error("rx ready held after frame");
	rx_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_dma_request |-> $past(ctrl_ff[`HDBP_CTRL_RX_DMA_EN])) else $error("rx request while disabled");
	irq_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff[`HDBP_CTRL_TX_IE] && !ctrl_ff[`HDBP_CTRL_RX_IE] |=> host_interrupt_n)
		else $error("interrupt without enable");

	tx_frame_c: cover property (@(posedge aclk) disable iff (!aresetn) tx_end);
	rx_frame_c: cover property (@(posedge aclk) disable iff (!aresetn) rx_end && rx_dma_request);

endmodule : hdbp_host_port
`default_nettype wire
